/* hw/wwp_defines.svh */
// Constants for the watchdog-window and group-protection register bank.
// Assumes a 10 MHz core clock and byte-wide registers reached over I2C.
`ifndef WWP_DEFINES_SVH
`define WWP_DEFINES_SVH

// ==========================================
// Register offsets
`define WWP_ADDR_OPEN      8'h82
`define WWP_ADDR_KEY       8'h83
`define WWP_ADDR_STATUS    8'h84
`define WWP_ADDR_LOCK1     8'hF0
`define WWP_ADDR_LOCK2     8'hF1
`define WWP_ADDR_TADDR     8'hF9

// ==========================================
// Reset values
`define WWP_KEY_RESET      8'h00
`define WWP_LOCK_RESET     7'h00
`define WWP_STATUS_RESET   3'h0

// ==========================================
// Lock bit positions
`define WWP_LOCK_BITS      7
`define WWP_BIT_WORKING    6
`define WWP_BIT_SLEEP_SEQ  5
`define WWP_BIT_POWER_SEQ  4
`define WWP_BIT_SLOT_CFG   3
`define WWP_BIT_WATCHDOG   2
`define WWP_BIT_COUNTER    1
`define WWP_BIT_CONTROL    0

// ==========================================
// Fault status bit positions
`define WWP_STATUS_BITS    3
`define WWP_STAT_EXT_RESET 0
`define WWP_STAT_EARLY_KEY 1
`define WWP_STAT_NO_KEY    2

// ==========================================
// Window code segments
`define WWP_SEG2_CODE      8'h20
`define WWP_SEG3_CODE      8'h40
`define WWP_SEG2_BASE_MS   34
`define WWP_SEG3_BASE_MS   100

// ==========================================
// Timing
`define WWP_CLK_PERIOD_NS  100
`define WWP_TICK_MS_NS     1000000
`define WWP_MS_CYCLES      (`WWP_TICK_MS_NS / `WWP_CLK_PERIOD_NS)

`endif

/* hw/wwp_pkg.sv */
// Types shared by the register bank and its window timers.
// Assumes wwp_defines.svh is available on the include path.
`default_nettype none

package wwp_pkg;
	typedef logic [7:0] wwp_byte_t;
	typedef enum logic [2:0] {WD_OFF, WD_DELAY_CLOSE, WD_DELAY_OPEN, WD_CLOSE, WD_OPEN} wwp_wd_state_t;
	typedef enum logic [3:0] {I_IDLE, I_ADDR, I_ADDR_ACK, I_REG, I_REG_ACK, I_WDATA, I_WDATA_ACK,
		I_RDATA, I_RACK} wwp_bus_state_t;
endpackage

`default_nettype wire

/* hw/wwp_window_timer.sv */
// Millisecond window timer driven by an eight-bit window code.
// Assumes start_i is a one-cycle pulse on the core clock.
`include "wwp_defines.svh"
`default_nettype none

module wwp_window_timer #(
	parameter int unsigned MS_CYCLES = `WWP_MS_CYCLES
) (
	input  wire logic             clock_i,
	input  wire logic             reset_i,
	input  wire logic             start_i,
	input  wire wwp_pkg::wwp_byte_t code_i,
	output logic                  done_o
);
	import wwp_pkg::*;

	localparam int unsigned CW = $clog2(MS_CYCLES);

	if (MS_CYCLES < 2) begin : g_bad_ms
		$error("MS_CYCLES must be at least 2");
	end

	logic [9:0]    code_ms;
	logic [9:0]    dur_ms;
	logic [9:0]    next_dur_ms;
	logic [9:0]    ms_cnt;
	logic [9:0]    next_ms_cnt;
	logic [CW-1:0] cyc;
	logic [CW-1:0] next_cyc;
	logic          busy;
	logic          next_busy;
	logic          next_done;

	// ==========================================
	// Code to duration and counting
	always_comb begin
		if (code_i < `WWP_SEG2_CODE) begin
			code_ms = 10'(code_i) + 10'h001;
		end else if (code_i < `WWP_SEG3_CODE) begin
			code_ms = 10'(`WWP_SEG2_BASE_MS) + (10'(code_i - `WWP_SEG2_CODE) << 1);
		end else begin
			code_ms = 10'(`WWP_SEG3_BASE_MS) + (10'(code_i - `WWP_SEG3_CODE) << 2);
		end
		next_dur_ms = dur_ms;
		next_ms_cnt = ms_cnt;
		next_cyc = cyc;
		next_busy = busy;
		next_done = 1'h0;
		if (start_i) begin
			next_dur_ms = code_ms;
			next_ms_cnt = 10'h001;
			next_cyc = '0;
			next_busy = 1'h1;
		end else if (busy) begin
			if (cyc == CW'(MS_CYCLES - 1)) begin
				next_cyc = '0;
				if (ms_cnt == dur_ms) begin
					next_done = 1'h1;
					next_busy = 1'h0;
				end else begin
					next_ms_cnt = ms_cnt + 10'h001;
				end
			end else begin
				next_cyc = cyc + CW'(1);
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			dur_ms <= 10'h000;
			ms_cnt <= 10'h000;
			cyc <= '0;
			busy <= 1'h0;
			done_o <= 1'h0;
		end else begin
			dur_ms <= next_dur_ms;
			ms_cnt <= next_ms_cnt;
			cyc <= next_cyc;
			busy <= next_busy;
			done_o <= next_done;
		end
	end

	// ==========================================
	// Checks
	property p_code_top;
		@(posedge clock_i) disable iff (reset_i) start_i && code_i == 8'hFF |=> dur_ms == 10'h360;
	endproperty
	a_code_top: assert property (p_code_top) else $error("code FF is not 864 ms");

	property p_code_seg2;
		@(posedge clock_i) disable iff (reset_i) start_i && code_i == 8'h20 |=> dur_ms == 10'h022;
	endproperty
	a_code_seg2: assert property (p_code_seg2) else $error("code 20 is not 34 ms");
endmodule

`default_nettype wire

/* hw/wwp_window_protect.sv */
// Watchdog window, service key, group protection and fault flag registers behind an I2C target.
// Assumes NVM values and self-test strobes come from logic on clock_i; I2C and reset pins are asynchronous.
`include "wwp_defines.svh"
`default_nettype none

// Contract
// - Open-window code maps 1/2/4 ms steps
// - Open window loads from NVM, lockable
// - Key register resets zero, key services watchdog
// - Group locked only when both bits set
// - Lock bits sticky until power removal
// - Self-test at shutdown clears both lock registers
// - Lock bit per register group, bit7 reserved
// - Writes to locked group silently ignored
// - Target address read-only, loaded from NVM
// - External reset pull-down raises fault interrupt
// - Period is close plus open, delay 1-8
module wwp_window_protect #(
	parameter int unsigned        MS_CYCLES   = `WWP_MS_CYCLES,
	parameter wwp_pkg::wwp_byte_t SERVICE_KEY = 8'h5A
) (
	input  wire logic                     clock_i,
	input  wire logic                     reset_i,
	input  wire logic                     scl_i,
	input  wire logic                     sda_i,
	output logic                          sda_o,
	output logic                          sda_oe_o,
	input  wire logic                     system_reset_n_i,
	output logic                          fault_interrupt_n_o,
	output logic                          fault_interrupt_n_oe_o,
	input  wire wwp_pkg::wwp_byte_t       stored_open_window_i,
	input  wire logic [6:0]               stored_target_address_i,
	input  wire logic                     watchdog_enable_i,
	input  wire logic [2:0]               first_delay_code_i,
	input  wire wwp_pkg::wwp_byte_t       watchdog_close_window_i,
	input  wire logic                     selftest_done_i,
	input  wire logic                     selftest_on_powerdown_i,
	output logic [`WWP_LOCK_BITS-1:0]     group_locked_o,
	output logic                          watchdog_expired_o
);
	import wwp_pkg::*;

	// ==========================================
	// Pin synchronisers
	logic scl_meta, scl_sync, scl_prev;
	logic sda_meta, sda_sync, sda_prev;
	logic rst_meta, rst_sync;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			scl_meta <= 1'h1;
			scl_sync <= 1'h1;
			scl_prev <= 1'h1;
			sda_meta <= 1'h1;
			sda_sync <= 1'h1;
			sda_prev <= 1'h1;
			rst_meta <= 1'h1;
			rst_sync <= 1'h1;
		end else begin
			scl_meta <= scl_i;
			scl_sync <= scl_meta;
			scl_prev <= scl_sync;
			sda_meta <= sda_i;
			sda_sync <= sda_meta;
			sda_prev <= sda_sync;
			rst_meta <= system_reset_n_i;
			rst_sync <= rst_meta;
		end
	end

	wire logic scl_rise = scl_sync & ~scl_prev;
	wire logic scl_fall = ~scl_sync & scl_prev;
	wire logic bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
	wire logic bus_stop = scl_sync & scl_prev & ~sda_prev & sda_sync;

	// ==========================================
	// Register storage
	wwp_byte_t                     open_window, next_open_window;
	wwp_byte_t                     service_key, next_service_key;
	logic [`WWP_LOCK_BITS-1:0]     lock_first, next_lock_first;
	logic [`WWP_LOCK_BITS-1:0]     lock_second, next_lock_second;
	logic [6:0]                    target_addr, next_target_addr;
	logic [`WWP_STATUS_BITS-1:0]   fault_status, next_fault_status;
	logic                          loaded, next_loaded;
	logic [`WWP_LOCK_BITS-1:0]     next_group_locked;
	logic                          next_irq_oe;
	logic                          reg_wr;
	wwp_byte_t                     wr_addr;
	wwp_byte_t                     wr_data;
	logic                          key_hit;
	logic                          early_key;
	logic                          no_key;
	logic                          wdt_locked;
	logic                          bist_clear;

	function automatic wwp_byte_t read_reg(input wwp_byte_t a);
		unique case (a)
			`WWP_ADDR_OPEN:   read_reg = open_window;
			`WWP_ADDR_KEY:    read_reg = service_key;
			`WWP_ADDR_LOCK1:  read_reg = {1'h0, lock_first};
			`WWP_ADDR_LOCK2:  read_reg = {1'h0, lock_second};
			`WWP_ADDR_TADDR:  read_reg = {1'h0, target_addr};
			`WWP_ADDR_STATUS: read_reg = {5'h00, fault_status};
			default:          read_reg = 8'h00;
		endcase
	endfunction

	assign wdt_locked = lock_first[`WWP_BIT_WATCHDOG] & lock_second[`WWP_BIT_WATCHDOG];
	assign bist_clear = selftest_done_i & selftest_on_powerdown_i;
	assign key_hit = reg_wr && wr_addr == `WWP_ADDR_KEY && wr_data == SERVICE_KEY;

	// ==========================================
	// I2C target
	wwp_bus_state_t i_state, next_i_state;
	logic [3:0]     bit_cnt, next_bit_cnt;
	wwp_byte_t      shreg, next_shreg;
	wwp_byte_t      rd_byte, next_rd_byte;
	wwp_byte_t      ptr, next_ptr;
	logic           next_sda_oe;
	wwp_byte_t      rd_here;
	wwp_byte_t      rd_after;

	always_comb begin
		rd_here = read_reg(ptr);
		rd_after = read_reg(ptr + 8'h01);
		next_i_state = i_state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_rd_byte = rd_byte;
		next_ptr = ptr;
		next_sda_oe = sda_oe_o;
		reg_wr = 1'h0;
		wr_addr = ptr;
		wr_data = shreg;
		if (bus_start) begin
			next_i_state = I_ADDR;
			next_bit_cnt = 4'h0;
			next_sda_oe = 1'h0;
		end else if (bus_stop) begin
			next_i_state = I_IDLE;
			next_sda_oe = 1'h0;
		end else if (scl_rise) begin
			if (i_state == I_ADDR || i_state == I_REG || i_state == I_WDATA) begin
				next_shreg = {shreg[6:0], sda_sync};
				next_bit_cnt = bit_cnt + 4'h1;
			end else if (i_state == I_RACK && sda_sync) begin
				next_i_state = I_IDLE;
			end
		end else if (scl_fall) begin
			unique case (i_state)
				I_ADDR: if (bit_cnt == 4'h8) begin
					if (shreg[7:1] == target_addr) begin
						next_i_state = I_ADDR_ACK;
						next_sda_oe = 1'h1;
					end else begin
						next_i_state = I_IDLE;
					end
				end
				I_ADDR_ACK: begin
					next_bit_cnt = 4'h0;
					next_sda_oe = 1'h0;
					next_i_state = I_REG;
					if (shreg[0]) begin
						next_rd_byte = rd_here;
						next_sda_oe = ~rd_here[7];
						next_bit_cnt = 4'h1;
						next_i_state = I_RDATA;
					end
				end
				I_REG: if (bit_cnt == 4'h8) begin
					next_ptr = shreg;
					next_sda_oe = 1'h1;
					next_i_state = I_REG_ACK;
				end
				I_WDATA: if (bit_cnt == 4'h8) begin
					reg_wr = 1'h1;
					next_ptr = ptr + 8'h01;
					next_sda_oe = 1'h1;
					next_i_state = I_WDATA_ACK;
				end
				I_REG_ACK, I_WDATA_ACK: begin
					next_bit_cnt = 4'h0;
					next_sda_oe = 1'h0;
					next_i_state = I_WDATA;
				end
				I_RDATA: begin
					if (bit_cnt == 4'h8) begin
						next_sda_oe = 1'h0;
						next_i_state = I_RACK;
					end else begin
						next_sda_oe = ~rd_byte[3'(4'h7 - bit_cnt)];
						next_bit_cnt = bit_cnt + 4'h1;
					end
				end
				I_RACK: begin
					next_ptr = ptr + 8'h01;
					next_rd_byte = rd_after;
					next_sda_oe = ~rd_after[7];
					next_bit_cnt = 4'h1;
					next_i_state = I_RDATA;
				end
				default: next_i_state = I_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			i_state <= I_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			rd_byte <= 8'h00;
			ptr <= 8'h00;
			sda_oe_o <= 1'h0;
			sda_o <= 1'h0;
		end else begin
			i_state <= next_i_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			rd_byte <= next_rd_byte;
			ptr <= next_ptr;
			sda_oe_o <= next_sda_oe;
			sda_o <= 1'h0;
		end
	end

	// ==========================================
	// Register updates
	always_comb begin
		next_open_window = open_window;
		next_service_key = service_key;
		next_lock_first = lock_first;
		next_lock_second = lock_second;
		next_target_addr = target_addr;
		next_fault_status = fault_status;
		next_loaded = 1'h1;
		if (!loaded) begin
			next_open_window = stored_open_window_i;
			next_target_addr = stored_target_address_i;
		end
		if (reg_wr) begin
			unique case (wr_addr)
				`WWP_ADDR_OPEN: if (!wdt_locked) next_open_window = wr_data;
				`WWP_ADDR_KEY:  next_service_key = wr_data;
				`WWP_ADDR_LOCK1: next_lock_first = lock_first | wr_data[6:0];
				`WWP_ADDR_LOCK2: next_lock_second = lock_second | wr_data[6:0];
				`WWP_ADDR_STATUS: next_fault_status = fault_status & ~wr_data[2:0];
				default: ;
			endcase
		end
		if (bist_clear) begin
			next_lock_first = `WWP_LOCK_RESET;
			next_lock_second = `WWP_LOCK_RESET;
		end
		next_fault_status[`WWP_STAT_EXT_RESET] = next_fault_status[`WWP_STAT_EXT_RESET] | ~rst_sync;
		next_fault_status[`WWP_STAT_EARLY_KEY] = next_fault_status[`WWP_STAT_EARLY_KEY] | early_key;
		next_fault_status[`WWP_STAT_NO_KEY] = next_fault_status[`WWP_STAT_NO_KEY] | no_key;
		next_group_locked = next_lock_first & next_lock_second;
		next_irq_oe = |next_fault_status;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			open_window <= 8'h00;
			service_key <= `WWP_KEY_RESET;
			lock_first <= `WWP_LOCK_RESET;
			lock_second <= `WWP_LOCK_RESET;
			target_addr <= 7'h00;
			fault_status <= `WWP_STATUS_RESET;
			loaded <= 1'h0;
			group_locked_o <= `WWP_LOCK_RESET;
			fault_interrupt_n_oe_o <= 1'h0;
			fault_interrupt_n_o <= 1'h0;
		end else begin
			open_window <= next_open_window;
			service_key <= next_service_key;
			lock_first <= next_lock_first;
			lock_second <= next_lock_second;
			target_addr <= next_target_addr;
			fault_status <= next_fault_status;
			loaded <= next_loaded;
			group_locked_o <= next_group_locked;
			fault_interrupt_n_oe_o <= next_irq_oe;
			fault_interrupt_n_o <= 1'h0;
		end
	end

	// ==========================================
	// Watchdog window sequence
	wwp_wd_state_t wd_state, next_wd_state;
	logic [2:0]    periods_left, next_periods_left;
	logic          start_close, start_open, close_done, open_done;

	always_comb begin
		next_wd_state = wd_state;
		next_periods_left = periods_left;
		start_close = 1'h0;
		start_open = 1'h0;
		early_key = 1'h0;
		no_key = 1'h0;
		if (!watchdog_enable_i || !loaded) begin
			next_wd_state = WD_OFF;
		end else begin
			unique case (wd_state)
				WD_OFF: begin
					next_periods_left = first_delay_code_i;
					start_close = 1'h1;
					next_wd_state = WD_DELAY_CLOSE;
				end
				WD_DELAY_CLOSE: if (close_done) begin
					start_open = 1'h1;
					next_wd_state = WD_DELAY_OPEN;
				end
				WD_DELAY_OPEN: if (open_done) begin
					start_close = 1'h1;
					if (periods_left == 3'h0) begin
						next_wd_state = WD_CLOSE;
					end else begin
						next_periods_left = periods_left - 3'h1;
						next_wd_state = WD_DELAY_CLOSE;
					end
				end
				WD_CLOSE: begin
					if (key_hit) begin
						early_key = 1'h1;
						start_close = 1'h1;
					end else if (close_done) begin
						start_open = 1'h1;
						next_wd_state = WD_OPEN;
					end
				end
				WD_OPEN: begin
					if (key_hit || open_done) begin
						no_key = ~key_hit;
						start_close = 1'h1;
						next_wd_state = WD_CLOSE;
					end
				end
				default: next_wd_state = WD_OFF;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wd_state <= WD_OFF;
			periods_left <= 3'h0;
			watchdog_expired_o <= 1'h0;
		end else begin
			wd_state <= next_wd_state;
			periods_left <= next_periods_left;
			watchdog_expired_o <= early_key | no_key;
		end
	end

	wwp_window_timer #(.MS_CYCLES(MS_CYCLES)) u_close_timer (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.start_i (start_close),
		.code_i  (watchdog_close_window_i),
		.done_o  (close_done)
	);

	wwp_window_timer #(.MS_CYCLES(MS_CYCLES)) u_open_timer (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.start_i (start_open),
		.code_i  (open_window),
		.done_o  (open_done)
	);

	// ==========================================
	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	property p_lock_sticky;
		!$past(bist_clear) |-> ((lock_first & $past(lock_first)) == $past(lock_first));
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit dropped");

	property p_selftest_clear;
		bist_clear |=> lock_first == 7'h00 && lock_second == 7'h00 && group_locked_o == 7'h00;
	endproperty
	a_selftest_clear: assert property (p_selftest_clear) else $error("self test left locks");

	property p_open_write;
		loaded && reg_wr && wr_addr == `WWP_ADDR_OPEN && !(lock_first[2] && lock_second[2])
			|=> open_window == $past(wr_data);
	endproperty
	a_open_write: assert property (p_open_write) else $error("open window write lost");

	property p_open_locked;
		reg_wr && wr_addr == `WWP_ADDR_OPEN && lock_first[2] && lock_second[2] |=> $stable(open_window);
	endproperty
	a_open_locked: assert property (p_open_locked) else $error("locked open window changed");

	property p_key_write;
		reg_wr && wr_addr == `WWP_ADDR_KEY |=> service_key == $past(wr_data);
	endproperty
	a_key_write: assert property (p_key_write) else $error("key not stored");

	property p_addr_fixed;
		loaded && $past(loaded) |-> $stable(target_addr);
	endproperty
	a_addr_fixed: assert property (p_addr_fixed) else $error("target address changed");

	property p_ext_fault;
		!rst_sync |=> fault_status[0] && fault_interrupt_n_oe_o;
	endproperty
	a_ext_fault: assert property (p_ext_fault) else $error("reset pull-down not flagged");

	property p_w1c;
		reg_wr && wr_addr == `WWP_ADDR_STATUS && wr_data[2] && !no_key |=> !fault_status[2];
	endproperty
	a_w1c: assert property (p_w1c) else $error("fault flag not cleared");

	property p_early_key;
		wd_state == WD_CLOSE && key_hit && watchdog_enable_i |=> fault_status[1] && watchdog_expired_o;
	endproperty
	a_early_key: assert property (p_early_key) else $error("early key not expiry");

	property p_delay_load;
		wd_state == WD_OFF && watchdog_enable_i && loaded |=> periods_left == $past(first_delay_code_i);
	endproperty
	a_delay_load: assert property (p_delay_load) else $error("delay count wrong");
endmodule

`default_nettype wire

/* tb/wwp_host.sv */
// Host model: bit-banged two-wire register writes and reads.
// Assumes a pulled-up data line wired-AND with the device; tasks start at a falling clock edge.
`default_nettype none

module wwp_host (
	input  wire logic       clock_i,
	input  wire logic       sda_i,
	input  wire logic [6:0] taddr_i,
	output var logic        scl_o,
	output var logic        pull_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end

	// ==========================================
	// Bit level
	task automatic half();
		repeat (10) @(negedge clock_i);
	endtask

	// Data moves only well after the clock fall
	task automatic bitx(input logic b, output logic r);
		repeat (3) @(negedge clock_i);
		pull_o = ~b;
		half();
		scl_o = 1'b1;
		half();
		r = sda_i;
		scl_o = 1'b0;
	endtask

	task automatic start();
		half();
		pull_o = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		pull_o = 1'b1;
		half();
		scl_o = 1'b0;
	endtask

	task automatic stop();
		half();
		pull_o = 1'b1;
		half();
		scl_o = 1'b1;
		half();
		pull_o = 1'b0;
		half();
	endtask

	task automatic xfer(input logic [7:0] d, output logic [7:0] q, input logic ak, output logic na);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(ak, na);
	endtask

	// ==========================================
	// Register transfers
	task automatic write_reg(input logic [7:0] r, v, output logic ok);
		logic [7:0] q;
		logic       n1, n2, n3;
		start();
		xfer({taddr_i, 1'b0}, q, 1'b1, n1);
		xfer(r, q, 1'b1, n2);
		xfer(v, q, 1'b1, n3);
		stop();
		ok = ~(n1 | n2 | n3);
	endtask

	task automatic read_reg(input logic [7:0] r, output logic [7:0] v, output logic ok);
		logic [7:0] q;
		logic       n1, n2, n3, n4;
		start();
		xfer({taddr_i, 1'b0}, q, 1'b1, n1);
		xfer(r, q, 1'b1, n2);
		start();
		xfer({taddr_i, 1'b1}, q, 1'b1, n3);
		xfer(8'hFF, v, 1'b1, n4);
		stop();
		ok = ~(n1 | n2 | n3);
	endtask
endmodule

`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the window and lock register bank.
// Assumes the host model owns the two-wire bus; 10 MHz core clock.
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; $display("BAD %0t %h %h", $time, (a), (e)); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import wwp_pkg::*;
	localparam int MSC = 4;

	logic       clock, reset, sys_rst_n, wd_en, st_done, st_pd, scl, pull, ok;
	logic       sda_oe, irq_oe, expired, sda_out, irq_out;
	logic [6:0] taddr, locked;
	logic [2:0] dly;
	wwp_byte_t  stored, close_c, rd, lk;
	wire logic  sda;
	int         seed = 32'h18D445DE;
	int         mismatches = 0;
	int         cmp_count = 0;
	int         t, n_exp = 0, n0, p;

	assign sda = ~pull & (sda_oe ? sda_out : 1'b1);

	wwp_window_protect #(.MS_CYCLES(MSC)) wwp_window_protect_i (
		.clock_i(clock), .reset_i(reset), .scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe),
		.system_reset_n_i(sys_rst_n), .fault_interrupt_n_o(irq_out), .fault_interrupt_n_oe_o(irq_oe),
		.stored_open_window_i(stored), .stored_target_address_i(taddr), .watchdog_enable_i(wd_en),
		.first_delay_code_i(dly), .watchdog_close_window_i(close_c), .selftest_done_i(st_done),
		.selftest_on_powerdown_i(st_pd), .group_locked_o(locked), .watchdog_expired_o(expired));

	wwp_host wwp_host_i (.clock_i(clock), .sda_i(sda), .taddr_i(taddr), .scl_o(scl), .pull_o(pull));

	// ==========================================
	// Expectations and helpers
	function automatic int ms(input logic [7:0] c);
		if (c < 8'h20) return int'(c) + 1;
		if (c < 8'h40) return 34 + 2 * (int'(c) - 32);
		return 100 + 4 * (int'(c) - 64);
	endfunction

	function automatic int near(input int a, e, tol);
		return ((a > e ? a - e : e - a) <= tol) ? e : a;
	endfunction

	task automatic wr(input wwp_byte_t r, v);
		wwp_host_i.write_reg(r, v, ok);
		`CHK(ok, 1'b1)
	endtask

	task automatic rdchk(input wwp_byte_t r, e);
		wwp_host_i.read_reg(r, rd, ok);
		`CHK({ok, rd}, {1'b1, e})
	endtask

	task automatic wexp(input int mx);
		t = 0;
		while (expired !== 1'b1 && t < mx) begin
			@(negedge clock);
			t++;
		end
		@(negedge clock);
	endtask

	// Missing keys only: first expiry after delay, then once a period
	task automatic wd(input wwp_byte_t op, cl, input logic [2:0] d);
		wd_en = 1'b0;
		wr(8'h82, op);
		close_c = cl;
		dly = d;
		p = (ms(op) + ms(cl)) * MSC;
		wd_en = 1'b1;
		wexp(p * (d + 2) + 200);
		`CHK(near(t, p * (d + 2), 6 * d + 12), p * (d + 2))
		wexp(p + 200);
		`CHK(near(t, p, 8), p)
	endtask

	task automatic finish_test();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(negedge clock) if (expired === 1'b1) n_exp++;

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	initial begin
		#(90000 * 100);
		mismatches++;
		finish_test();
	end

	// ==========================================
	// Main sequence
	initial begin
		reset = 1'b1;
		{sys_rst_n, wd_en, st_done, st_pd, dly, close_c} = {1'b1, 14'h0};
		stored = wwp_byte_t'($random(seed));
		taddr = 7'($random(seed));
		repeat (6) @(negedge clock);
		reset = 1'b0;
		repeat (6) @(negedge clock);
		rdchk(8'h82, stored);
		rdchk(8'h83, 8'h00);
		rdchk(8'hF1, 8'h00);
		wr(8'hF9, 8'hFF);
		rdchk(8'hF9, {1'b0, taddr});
		rdchk(8'h90, 8'h00);
		sys_rst_n = 1'b0;
		repeat (8) @(negedge clock);
		`CHK(irq_oe, 1'b1)
		`CHK({sda_out, irq_out}, 2'b00)
		sys_rst_n = 1'b1;
		rdchk(8'h84, 8'h01);
		wr(8'h84, 8'h01);
		rdchk(8'h84, 8'h00);
		`CHK(irq_oe, 1'b0)
		wd(8'h1F, 8'h20, 3'h7);
		wd(8'h3F, 8'h40, 3'h0);
		wd(8'hFF, 8'h00, 3'($random(seed) & 3));
		// Key lands in the open window and restarts the cycle
		wr(8'h83, 8'h5A);
		close_c = 8'hFF;
		wexp(p + 200);
		`CHK(near(t, p - 60, 16), p - 60)
		rdchk(8'h84, 8'h04);
		n0 = n_exp;
		wr(8'h83, 8'h5A);
		`CHK(n_exp - n0, 1)
		rdchk(8'h84, 8'h06);
		wd_en = 1'b0;
		wr(8'h84, 8'h07);
		`CHK(irq_oe, 1'b0)
		wr(8'hF0, 8'hFF);
		rdchk(8'hF0, 8'h7F);
		`CHK(locked, 7'h00)
		wr(8'h82, 8'h11);
		rdchk(8'h82, 8'h11);
		lk = wwp_byte_t'($random(seed)) | 8'h04;
		wr(8'hF1, lk);
		`CHK(locked, lk[6:0])
		wr(8'hF1, 8'h00);
		rdchk(8'hF1, {1'b0, lk[6:0]});
		wr(8'h82, 8'hEE);
		rdchk(8'h82, 8'h11);
		wr(8'h83, 8'h33);
		rdchk(8'h83, 8'h33);
		st_done = 1'b1;
		@(negedge clock);
		st_done = 1'b0;
		rdchk(8'hF0, 8'h7F);
		st_pd = 1'b1;
		st_done = 1'b1;
		@(negedge clock);
		st_done = 1'b0;
		rdchk(8'hF1, 8'h00);
		`CHK(locked, 7'h00)
		wr(8'h82, 8'hEE);
		rdchk(8'h82, 8'hEE);
		finish_test();
	end
endmodule

`default_nettype wire
